// [core/scm_correct.sv]
// Correction datapath: compensates a raw capacitance reading for temperature,
// applies the selected polynomial and corrects the internal temperature.
// Assumes conversions and the register master share core_clk_i.
//
// Notes on behaviour
// [RL1] Two-region or single-region cubic correction selectable.
// [RL2] Compensated value: drifted offset sum over drifted gain.
// [RL3] Region one min, region two positive excess.
// [RL4] Two-region output sums square and linear terms.
// [RL5] Cubic mode uses region two square storage.
// [RL6] Single region ignores region two coefficients.
// [RL7] dT is raw temperature minus reference.
// [RL8] Temperature: square, slope and bias terms.
// [RL9] Raw temperature 0..16383, result signed 16-bit.
// [RL10] Temperature coefficients are signed 16-bit.
// [RL11] Offset applies about mid-scale input.
// [RL12] Offset drift limits kept by calibration.
// [RL13] Gain drift limits kept by calibration.
// [RL14] Alarm-only users verify coefficients beforehand.
// [RL15] Calibration computes config bits three and four.
// [RL16] Recompute per conversion, hold results between; a pending pair overwritten by a newer conversion is dropped unprocessed.
`timescale 1ns/1ps
module scm_correct
	import scm_pkg::*;
(
	// Clock and reset.
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	// Register port.
	input wire logic [4:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	// Converter front end.
	input wire logic conv_done_i,
	input wire logic [13:0] raw_cap_i,
	input wire logic [13:0] raw_temp_i,
	// Results.
	output logic [15:0] cap_out_o,
	output logic [15:0] temp_out_o,
	output logic result_valid_o,
	output logic busy_o
);

	function automatic logic signed [47:0] sx(input logic [15:0] v);
		return {{32{v[15]}}, v};
	endfunction

	function automatic logic signed [47:0] mulsh(input logic signed [47:0] a,
		input logic signed [47:0] b, input int unsigned sh);
		return (a * b) >>> sh;
	endfunction

	function automatic logic [15:0] sat16(input logic signed [47:0] x);
		if (x > SAT_MAX) begin
			return SAT_MAX[15:0];
		end
		if (x < SAT_MIN) begin
			return SAT_MIN[15:0];
		end
		return x[15:0];
	endfunction

	// Register group.
	logic [15:0] coef_q [A_OFFSET:A_TSQ];
	logic [15:0] coef_d [A_OFFSET:A_TSQ];
	logic [1:0] mode_q, mode_d;
	logic [15:0] rdata_q, rdata_d;
	scm_state_t state_q, state_d;
	logic pend_q, pend_d;
	logic [15:0] cap_q, temp_q;

	always_comb begin
		coef_d = coef_q;
		mode_d = mode_q;
		rdata_d = 16'h0000;
		if (wr_i) begin
			if (addr_i == A_CTRL) begin
				mode_d = wdata_i[MODE_LSB +: 2];
			end else if (addr_i >= A_OFFSET && addr_i <= A_TSQ) begin
				coef_d[addr_i] = wdata_i;
			end
		end
		if (rd_i) begin
			if (addr_i == A_CTRL) begin
				rdata_d = {14'h0000, mode_q};
			end else if (addr_i >= A_OFFSET && addr_i <= A_TSQ) begin
				rdata_d = coef_q[addr_i];
			end else if (addr_i == A_STATUS) begin
				rdata_d[ST_BUSY_BIT] = (state_q != ST_IDLE);
				rdata_d[ST_PEND_BIT] = pend_q;
			end else if (addr_i == A_CAP_OUT) begin
				rdata_d = cap_q;
			end else if (addr_i == A_TEMP_OUT) begin
				rdata_d = temp_q;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			for (int i = A_OFFSET; i <= A_TSQ; i++) begin
				coef_q[i] <= COEF_RST;
			end
			coef_q[A_GAIN1] <= GAIN_RST;
			coef_q[A_GAIN2] <= GAIN_RST;
			mode_q <= MODE_RST;
			rdata_q <= 16'h0000;
		end else begin
			coef_q <= coef_d;
			mode_q <= mode_d;
			rdata_q <= rdata_d;
		end
	end

	assign rdata_o = rdata_q;

	// Datapath group.
	logic [13:0] lat_c_q, lat_c_d, lat_t_q, lat_t_d, rt_q, rt_d;
	logic signed [15:0] dt_q, dt_d, comp_q, comp_d;
	logic signed [15:0] r1_q, r1_d, r2_q, r2_d, u1_q, u1_d, u2_q, u2_d;
	logic signed [47:0] num_q, num_d, den_q, den_d;
	logic [15:0] cap_d, temp_d;
	logic valid_q, valid_d;
	logic signed [15:0] brk;
	assign brk = coef_q[A_BREAK];

	always_comb begin
		logic signed [47:0] dtx, dr, gr, sq1, acc, rtx, t;
		dtx = '0;
		dr = '0;
		gr = '0;
		sq1 = '0;
		acc = '0;
		rtx = '0;
		t = '0;
		state_d = state_q;
		lat_c_d = lat_c_q;
		lat_t_d = lat_t_q;
		rt_d = rt_q;
		dt_d = dt_q;
		num_d = num_q;
		den_d = den_q;
		comp_d = comp_q;
		r1_d = r1_q;
		r2_d = r2_q;
		u1_d = u1_q;
		u2_d = u2_q;
		cap_d = cap_q;
		temp_d = temp_q;
		valid_d = 1'b0;
		pend_d = pend_q;
		// Only the newest reading pair is kept; older unprocessed pairs are dropped.
		if (state_q == ST_IDLE && pend_q) begin
			pend_d = 1'b0;
		end
		if (conv_done_i) begin // [RL16]
			lat_c_d = raw_cap_i;
			lat_t_d = raw_temp_i;
			pend_d = 1'b1;
		end
		case (state_q)
			ST_IDLE: begin
				if (pend_q) begin
					dtx = sx({2'b00, lat_t_q}) - sx(coef_q[A_TREF]); // [RL7]
					dt_d = sat16(dtx);
					rt_d = lat_t_q;
					dr = sx(coef_q[A_TCO]) + mulsh(dtx, sx(coef_q[A_TCO_SQ]), Q15_SH);
					num_d = sx({2'b00, lat_c_q}) - MID_SCALE + sx(coef_q[A_OFFSET]) // [RL11]
						+ mulsh(dtx, dr, Q15_SH); // [RL2]
					gr = sx(coef_q[A_TCG]) + mulsh(dtx, sx(coef_q[A_TCG_SQ]), Q15_SH);
					den_d = DEN_ONE + mulsh(dtx, gr, Q15_SH); // [RL2]
					state_d = ST_DIV;
				end
			end
			ST_DIV: begin
				// A non-positive divisor only arises outside the calibration limits.
				if (den_q < DEN_MIN) begin // [RL12] [RL13]
					comp_d = sat16((num_q <<< Q15_SH) / DEN_MIN);
				end else begin
					comp_d = sat16((num_q <<< Q15_SH) / den_q); // [RL2]
				end
				state_d = ST_REG;
			end
			ST_REG: begin
				if (mode_q == MODE_TWO) begin // [RL1]
					r1_d = (comp_q < brk) ? comp_q : brk; // [RL3]
					acc = sx(comp_q) - sx(brk);
					r2_d = (acc > 0) ? sat16(acc) : 16'sh0000; // [RL3]
				end else begin
					r1_d = comp_q; // [RL5]
					r2_d = 16'sh0000; // [RL6]
				end
				state_d = ST_POLY;
			end
			ST_POLY: begin
				u1_d = sat16(mulsh(sx(coef_q[A_GAIN1]), sx(r1_q), GAIN_SH));
				u2_d = sat16(mulsh(sx(coef_q[A_GAIN2]), sx(r2_q), GAIN_SH));
				sq1 = mulsh(sx(u1_d), sx(u1_d), Q15_SH);
				acc = mulsh(sx(coef_q[A_SQ1]), sq1, Q15_SH) + sx(u1_d);
				if (mode_q == MODE_CUBIC) begin // [RL5]
					acc = acc + mulsh(sx(coef_q[A_SQ2]), mulsh(sq1, sx(u1_d), Q15_SH), Q15_SH);
				end else if (mode_q == MODE_TWO) begin // [RL4]
					acc = acc + sx(u2_d)
						+ mulsh(sx(coef_q[A_SQ2]), mulsh(sx(u2_d), sx(u2_d), Q15_SH), Q15_SH);
				end
				cap_d = sat16(acc);
				rtx = sx({2'b00, rt_q}); // [RL9]
				t = mulsh(sx(coef_q[A_TSQ]), rtx * rtx, TSQ_SH) // [RL10]
					+ mulsh(sx(coef_q[A_TGAIN]), rtx, TGAIN_SH) + sx(coef_q[A_TOFF]);
				temp_d = sat16(t); // [RL8] [RL9]
				valid_d = 1'b1;
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			state_q <= ST_IDLE;
			pend_q <= 1'b0;
			lat_c_q <= 14'h0000;
			lat_t_q <= 14'h0000;
			rt_q <= 14'h0000;
			dt_q <= 16'sh0000;
			num_q <= '0;
			den_q <= DEN_ONE;
			comp_q <= 16'sh0000;
			r1_q <= 16'sh0000;
			r2_q <= 16'sh0000;
			u1_q <= 16'sh0000;
			u2_q <= 16'sh0000;
			cap_q <= 16'h0000;
			temp_q <= 16'h0000;
			valid_q <= 1'b0;
		end else begin
			state_q <= state_d;
			pend_q <= pend_d;
			lat_c_q <= lat_c_d;
			lat_t_q <= lat_t_d;
			rt_q <= rt_d;
			dt_q <= dt_d;
			num_q <= num_d;
			den_q <= den_d;
			comp_q <= comp_d;
			r1_q <= r1_d;
			r2_q <= r2_d;
			u1_q <= u1_d;
			u2_q <= u2_d;
			cap_q <= cap_d;
			temp_q <= temp_d;
			valid_q <= valid_d;
		end
	end

	assign cap_out_o = cap_q;
	assign temp_out_o = temp_q;
	assign result_valid_o = valid_q;
	logic busy_q;
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= (state_d != ST_IDLE);
		end
	end
	assign busy_o = busy_q;

	// Checks.
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	run_latency_a: assert property ( // [RL16]
		state_q == ST_IDLE && pend_q |-> ##4 result_valid_o)
		else $error("result not produced four cycles after start");
	run_pulse_a: assert property ( // [RL16]
		result_valid_o |=> !result_valid_o [*3])
		else $error("result strobe repeated too soon");
	hold_out_a: assert property ( // [RL16]
		!valid_q && state_q != ST_POLY |=> $stable(cap_out_o) && $stable(temp_out_o))
		else $error("outputs changed without a finished computation");
	delta_t_a: assert property ( // [RL7]
		state_q == ST_IDLE && pend_q && lat_t_q == 14'h0000 && coef_q[A_TREF] == 16'h0000
		|=> dt_q == 16'sh0000)
		else $error("temperature delta wrong");
	mid_off_a: assert property ( // [RL11]
		state_q == ST_IDLE && pend_q && lat_t_q == coef_q[A_TREF][13:0]
		&& !coef_q[A_TREF][15] && coef_q[A_TREF][14] == 1'b0
		|=> num_q == sx({2'b00, $past(lat_c_q)}) - MID_SCALE + sx($past(coef_q[A_OFFSET]))
		&& den_q == DEN_ONE)
		else $error("offset or divisor wrong at reference temperature");
	region_min_a: assert property ( // [RL3]
		state_q == ST_REG && mode_q == MODE_TWO |=> r1_q <= $past(brk) && r2_q >= 0)
		else $error("region split out of bounds");
	single_reg_a: assert property ( // [RL6]
		state_q == ST_REG && mode_q != MODE_TWO |=> r2_q == 0 && r1_q == $past(comp_q))
		else $error("single region did not bypass split");
	zero_out_a: assert property ( // [RL4]
		state_q == ST_POLY && r1_q == 0 && r2_q == 0 ##1 1'b1 |-> cap_out_o == 16'h0000)
		else $error("polynomial of zero inputs not zero");
	temp_bias_a: assert property ( // [RL8]
		state_q == ST_POLY && rt_q == 14'h0000 |=> temp_out_o == $past(coef_q[A_TOFF]))
		else $error("temperature at zero reading not the bias");
	cover_two_c: cover property (state_q == ST_REG && mode_q == MODE_TWO && comp_q > brk);
	cover_cubic_c: cover property (result_valid_o && mode_q == MODE_CUBIC);
	cover_pend_c: cover property (conv_done_i && state_q != ST_IDLE);
	cover_tsat_c: cover property (result_valid_o && temp_out_o == 16'h7fff);
endmodule

// [core/scm_pkg.sv]
// Constants, types and register map of the sensor correction datapath.
// Assumes a single 100 MHz clock shared by bus master and converter front end.
package scm_pkg;
	// Register offsets on the 5-bit register port.
	localparam logic [4:0] A_CTRL = 5'h00;
	localparam logic [4:0] A_OFFSET = 5'h01;
	localparam logic [4:0] A_GAIN1 = 5'h02;
	localparam logic [4:0] A_GAIN2 = 5'h03;
	localparam logic [4:0] A_SQ1 = 5'h04;
	localparam logic [4:0] A_SQ2 = 5'h05;
	localparam logic [4:0] A_TCO = 5'h06;
	localparam logic [4:0] A_TCG = 5'h07;
	localparam logic [4:0] A_TCO_SQ = 5'h08;
	localparam logic [4:0] A_TCG_SQ = 5'h09;
	localparam logic [4:0] A_TREF = 5'h0a;
	localparam logic [4:0] A_BREAK = 5'h0b;
	localparam logic [4:0] A_TGAIN = 5'h0c;
	localparam logic [4:0] A_TOFF = 5'h0d;
	localparam logic [4:0] A_TSQ = 5'h0e;
	localparam logic [4:0] A_STATUS = 5'h0f;
	localparam logic [4:0] A_CAP_OUT = 5'h10;
	localparam logic [4:0] A_TEMP_OUT = 5'h11;
	// Field positions.
	localparam int unsigned MODE_LSB = 0;
	localparam int unsigned ST_BUSY_BIT = 0;
	localparam int unsigned ST_PEND_BIT = 1;
	// Reset values.
	localparam logic [15:0] COEF_RST = 16'h0000;
	localparam logic [15:0] GAIN_RST = 16'h2000;
	localparam logic [1:0] MODE_RST = 2'h0;
	// Fixed-point scaling: drift and capacitance square terms are Q1.15, region gains Q3.13; temperature slope and square use shifts 14 and 28.
	localparam int unsigned Q15_SH = 15;
	localparam int unsigned GAIN_SH = 13;
	localparam int unsigned TSQ_SH = 28;
	localparam int unsigned TGAIN_SH = 14;
	localparam logic signed [47:0] MID_SCALE = 48'sh0000_0000_2000;
	localparam logic signed [47:0] DEN_ONE = 48'sh0000_0000_8000;
	localparam logic signed [47:0] DEN_MIN = 48'sh0000_0000_0001;
	localparam logic signed [47:0] SAT_MAX = 48'sh0000_0000_7fff;
	localparam logic signed [47:0] SAT_MIN = 48'shffff_ffff_8000;
	typedef enum logic [1:0] {
		MODE_TWO = 2'b00,
		MODE_ONE = 2'b01,
		MODE_CUBIC = 2'b10
	} scm_mode_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DIV = 2'b01,
		ST_REG = 2'b10,
		ST_POLY = 2'b11
	} scm_state_t;
endpackage

// [verif/tb_top.sv]
// Self-checking bench for the correction datapath: a table of conversions, then hand tests.
// Assumes scm_pkg and scm_correct are compiled first and a single 100 MHz clock.
`timescale 1ns/1ps
module tb_top;
	import scm_pkg::*;
	logic core_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [4:0] addr_i = 5'h00;
	logic [15:0] wdata_i = 16'h0000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic conv_done_i = 1'b0;
	logic [13:0] raw_cap_i = 14'h0000;
	logic [13:0] raw_temp_i = 14'h0000;
	logic [15:0] rdata_o;
	logic [15:0] cap_out_o;
	logic [15:0] temp_out_o;
	logic result_valid_o;
	logic busy_o;
	int n_mismatch = 0;
	int samples_checked = 0;
	int cycles = 0;
	int lat;
	int pulses;
	logic seen_busy;
	logic [15:0] rd_v;
	// Columns: mode, region two gain, breakpoint, raw cap, raw temp, expected cap.
	// Gains are exact powers of two so every expected value is free of rounding.
	logic [15:0] rows [7][6] = '{
		'{16'h0000, 16'h2000, 16'h0000, 16'h2100, 16'h0000, 16'h0100},
		'{16'h0000, 16'h4000, 16'h0100, 16'h2300, 16'h0100, 16'h0500},
		'{16'h0000, 16'h4000, 16'h0100, 16'h2080, 16'h0200, 16'h0080},
		'{16'h0000, 16'h4000, 16'h0100, 16'h1f00, 16'h1000, 16'hff00},
		'{16'h0001, 16'h4000, 16'h0100, 16'h2300, 16'h2000, 16'h0300},
		'{16'h0002, 16'h4000, 16'h0100, 16'h2300, 16'h3fff, 16'h0300},
		'{16'h0003, 16'h4000, 16'h0100, 16'h2300, 16'h0064, 16'h0300}};

	scm_correct dut_u (
		.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .conv_done_i(conv_done_i),
		.raw_cap_i(raw_cap_i), .raw_temp_i(raw_temp_i), .cap_out_o(cap_out_o),
		.temp_out_o(temp_out_o), .result_valid_o(result_valid_o), .busy_o(busy_o));

	always #5 core_clk_i = ~core_clk_i;

	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// The whole run needs a few hundred cycles; this ceiling only catches a hang.
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			stop_test();
		end
	end

	task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_diff(input string what, input logic [15:0] old, input logic [15:0] got);
		samples_checked++;
		if (got === old || $isunknown(got)) begin
			n_mismatch++;
			$display("unexpected %s: expected not %h seen %h", what, old, got);
		end
	endtask

	task automatic bus_wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge core_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic bus_rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge core_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask

	task automatic conv(input logic [15:0] cap, input logic [15:0] temp);
		@(posedge core_clk_i);
		raw_cap_i <= cap[13:0];
		raw_temp_i <= temp[13:0];
		conv_done_i <= 1'b1;
		@(posedge core_clk_i);
		conv_done_i <= 1'b0;
		#1;
		lat = 0;
		seen_busy = 1'b0;
		while (lat < 20 && result_valid_o !== 1'b1) begin
			@(posedge core_clk_i);
			#1;
			lat++;
			if (busy_o === 1'b1) seen_busy = 1'b1;
		end
		chk_val("latency", 16'h0004, lat[15:0]);
		chk_val("busy_o seen", 16'h0001, {15'h0000, seen_busy});
		chk_val("busy_o idle", 16'h0000, {15'h0000, busy_o});
	endtask

	initial begin
		repeat (12) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		@(posedge core_clk_i);
		#1;
		chk_val("cap_out_o", 16'h0000, cap_out_o);
		bus_rd(A_CTRL, rd_v);
		chk_val("mode", 16'h0000, rd_v);
		@(posedge core_clk_i);
		#1;
		chk_val("rdata_o", 16'h0000, rdata_o);
		bus_rd(A_GAIN1, rd_v);
		chk_val("gain1", 16'h2000, rd_v);
		bus_wr(A_CAP_OUT, 16'h1234);
		bus_rd(A_CAP_OUT, rd_v);
		chk_val("cap result", 16'h0000, rd_v);
		bus_rd(5'h1f, rd_v);
		chk_val("unmapped", 16'h0000, rd_v);
		// Coefficients are stored as written, without any range check.
		// The factory configuration word and its computed bits three and four are not here.
		bus_wr(A_TGAIN, 16'h4000);
		bus_wr(A_TOFF, 16'hff9c);
		for (int i = 0; i < 7; i++) begin
			bus_wr(A_CTRL, rows[i][0]);
			bus_wr(A_GAIN2, rows[i][1]);
			bus_wr(A_BREAK, rows[i][2]);
			conv(rows[i][3], rows[i][4]);
			chk_val("cap_out_o", rows[i][5], cap_out_o);
			chk_val("temp_out_o", rows[i][4] + 16'hff9c, temp_out_o);
		end
		bus_wr(A_CTRL, 16'h0000);
		bus_wr(A_GAIN2, 16'h2000);
		bus_wr(A_BREAK, 16'h0000);
		// Drift coefficients stay inside the calibration limits, so the divisor stays positive.
		bus_wr(A_TCO, 16'h4000);
		bus_wr(A_TCG, 16'h0000);
		bus_wr(A_OFFSET, 16'h0010);
		bus_wr(A_TREF, 16'h0100);
		conv(16'h2100, 16'h0300);
		chk_val("cap_out_o", 16'h0210, cap_out_o);
		bus_wr(A_TREF, 16'h0300);
		conv(16'h2100, 16'h0300);
		chk_val("cap_out_o", 16'h0110, cap_out_o);
		bus_wr(A_TCO, 16'h0000);
		bus_wr(A_OFFSET, 16'h0000);
		// Large values keep the nonlinear terms clear of any truncation to zero.
		bus_wr(A_SQ2, 16'h7fff);
		bus_wr(A_BREAK, 16'h0100);
		conv(16'h2080, 16'h0000);
		chk_val("cap_out_o", 16'h0080, cap_out_o);
		conv(16'h3f00, 16'h0000);
		chk_diff("cap_out_o", 16'h1f00, cap_out_o);
		bus_wr(A_CTRL, 16'h0001);
		conv(16'h3f00, 16'h0000);
		chk_val("cap_out_o", 16'h1f00, cap_out_o);
		bus_wr(A_CTRL, 16'h0002);
		conv(16'h3f00, 16'h0000);
		chk_diff("cap_out_o", 16'h1f00, cap_out_o);
		bus_wr(A_SQ2, 16'h0000);
		conv(16'h3f00, 16'h0000);
		chk_val("cap_out_o", 16'h1f00, cap_out_o);
		bus_wr(A_TSQ, 16'h4000);
		bus_wr(A_TGAIN, 16'h0000);
		bus_wr(A_TOFF, 16'h0000);
		conv(16'h2000, 16'h2000);
		chk_val("temp_out_o", 16'h1000, temp_out_o);
		bus_wr(A_TSQ, 16'h0000);
		bus_wr(A_TGAIN, 16'h7fff);
		bus_wr(A_TOFF, 16'h7fff);
		conv(16'h2000, 16'h3fff);
		chk_val("temp_out_o", 16'h7fff, temp_out_o);
		bus_wr(A_TGAIN, 16'h8000);
		bus_wr(A_TOFF, 16'h8000);
		conv(16'h2000, 16'h3fff);
		chk_val("temp_out_o", 16'h8000, temp_out_o);
		// Three conversions in quick succession: the third replaces the pending second.
		bus_wr(A_CTRL, 16'h0001);
		@(posedge core_clk_i);
		raw_cap_i <= 14'h2010;
		conv_done_i <= 1'b1;
		@(posedge core_clk_i);
		raw_cap_i <= 14'h2020;
		@(posedge core_clk_i);
		conv_done_i <= 1'b0;
		@(posedge core_clk_i);
		raw_cap_i <= 14'h2030;
		conv_done_i <= 1'b1;
		@(posedge core_clk_i);
		conv_done_i <= 1'b0;
		pulses = 0;
		// The first result strobe comes one cycle after this one; the loop looks before each wait.
		repeat (20) begin
			#1;
			if (result_valid_o === 1'b1) begin
				pulses++;
				if (pulses == 1) chk_val("first result", 16'h0010, cap_out_o);
			end
			@(posedge core_clk_i);
		end
		#1;
		chk_val("result pulses", 16'h0002, pulses[15:0]);
		chk_val("held result", 16'h0030, cap_out_o);
		stop_test();
	end
endmodule
